// ===== bench/host_port.sv
// host model driving the register port
`timescale 1ns/10ps
module host_port (
   // clock
   input logic clk_sys,
   // register port
   output logic [7:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input logic [31:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   // data inverted on release so stale data never looks valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
endmodule // host_port

// ===== bench/power_bin_regs_assertions.sv
// port assertions of the power-bin register bank
`timescale 1ns/10ps
module power_bin_regs_assertions (
   // clock and reset
   input logic clk_sys,
   input logic rstn,
   // register port
   input logic [7:0] reg_addr,
   input logic [31:0] reg_wdata,
   input logic reg_write,
   input logic reg_read,
   input logic [31:0] reg_rdata,
   // status and pacing
   input logic meas_start,
   input logic data_produced,
   input logic frame_lost,
   input logic service_created,
   // configuration
   input logic [9:0] cfg_gain,
   input logic [2:0] cfg_power_level,
   input logic cfg_hibernate,
   input logic tx_enable,
   input logic [2:0] cfg_preset,
   input logic cfg_noise_scaling,
   input logic cfg_async_mode,
   input logic cfg_long_span,
   input logic [31:0] cfg_bin_total
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////////
   property p_rd_idle;
      !reg_read |=> reg_rdata == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_mute;
      reg_write && reg_addr == 8'h26 |=> tx_enable == ($past(reg_wdata) == 32'h0);
   endproperty
   a_mute: assert property (p_mute) else $error("mute not applied");
   property p_gain_ok;
      reg_write && reg_addr == 8'h24 && reg_wdata <= 32'h3e8 |=> cfg_gain == $past(reg_wdata[9:0]);
   endproperty
   a_gain_ok: assert property (p_gain_ok) else $error("gain not taken");
   property p_gain_bad;
      reg_write && reg_addr == 8'h24 && reg_wdata > 32'h3e8 |=> $stable(cfg_gain);
   endproperty
   a_gain_bad: assert property (p_gain_bad) else $error("gain over range taken");
   property p_hib;
      cfg_hibernate == (cfg_power_level == 3'h4);
   endproperty
   a_hib: assert property (p_hib) else $error("hibernate decode wrong");
   property p_preset;
      cfg_preset inside {[3'h1:3'h5]};
   endproperty
   a_preset: assert property (p_preset) else $error("preset out of range");
   property p_span;
      reg_write && reg_addr == 8'h34 && reg_wdata == 32'h9 |=> cfg_long_span;
   endproperty
   a_span: assert property (p_span) else $error("long span not selected");
   property p_norm;
      reg_write && reg_addr == 8'h31 |=> cfg_noise_scaling == ($past(reg_wdata) != 32'h0);
   endproperty
   a_norm: assert property (p_norm) else $error("noise scaling wrong");
   property p_async;
      reg_write && reg_addr == 8'h33 |=> cfg_async_mode == ($past(reg_wdata) != 32'h0);
   endproperty
   a_async: assert property (p_async) else $error("async mode wrong");
   property p_bins;
      reg_write && reg_addr == 8'h40 |=> cfg_bin_total == $past(reg_wdata);
   endproperty
   a_bins: assert property (p_bins) else $error("bin total not taken");
   property p_hold;
      !reg_write |=> $stable(cfg_bin_total) && $stable(cfg_gain);
   endproperty
   a_hold: assert property (p_hold) else $error("config moved without write");
   sequence s_lost;
      data_produced && frame_lost ##1 !data_produced && !service_created;
   endsequence
   property p_lost;
      s_lost ##1 reg_read && reg_addr == 8'ha1 |=> reg_rdata == 32'h1;
   endproperty
   a_lost: assert property (p_lost) else $error("lost flag not set");
   ////////////////////////////////////////////////////////////////////////////////
   c_start: cover property (meas_start);
   c_hib: cover property (cfg_hibernate);
   c_lost: cover property (s_lost ##1 reg_read && reg_addr == 8'ha1);
endmodule // power_bin_regs_assertions

bind power_bin_regs power_bin_regs_assertions u_chk (.*);

// ===== bench/power_bin_regs_tb.sv
// self-checking bench of the power-bin register bank
`timescale 1ns/10ps
module power_bin_regs_tb;
   import pbin_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic reg_write, reg_read, meas_start, cfg_hibernate, tx_enable;
   logic meas_request = 1'b0, service_created = 1'b0, data_produced = 1'b0;
   logic frame_saturated = 1'b0, frame_lost = 1'b0, frame_poor = 1'b0, link_failed = 1'b0;
   logic [31:0] created_begin_mm, created_span_mm, created_bins;
   logic [31:0] created_stitches, created_spacing_um;
   logic [31:0] cfg_begin_mm, cfg_span_mm, cfg_decimation, cfg_averaging, cfg_bin_total;
   logic [9:0] cfg_gain;
   logic [2:0] cfg_power_level, cfg_preset;
   logic cfg_noise_scaling, cfg_attenuation_max, cfg_async_mode, cfg_long_span;
   logic [31:0] mdl [256];
   bit rw [256];
   logic [7:0] codes [5] = '{8'h22, 8'h25, 8'h28, 8'h34, 8'h26};
   int error_cnt = 0;
   int checks_done = 0;
   always #2.5 clk_sys = ~clk_sys;
   host_port u_host (.*);
   power_bin_regs u_dut (.*);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic mreset;
      foreach (mdl[i]) mdl[i] = 32'h0;
      for (int i = 0; i < CFG_COUNT; i++) begin
         mdl[CFG_OFFSET[i]] = CFG_RESET[i];
         rw[CFG_OFFSET[i]] = 1'b1;
      end
   endtask
   function automatic bit legal(input logic [7:0] a, input logic [31:0] d);
      case (a)
         OFS_CADENCE_POLICY: return d == 1 || d == 2;
         OFS_RECEIVER_AMPLIFICATION: return d <= 1000;
         OFS_RADAR_SLEEP_LEVEL: return d <= 4;
         OFS_RX_TX_PRESET: return d >= 1 && d <= 5;
         OFS_UNAMBIGUOUS_SPAN_SEL: return d == 6 || d == 9;
         default: return rw[a];
      endcase
   endfunction
   task automatic chk_cfg;
      chk(cfg_begin_mm, mdl[8'h20], "begin");
      chk(cfg_span_mm, mdl[8'h21], "span");
      chk(32'(cfg_gain), mdl[8'h24], "gain");
      chk(32'(cfg_power_level), mdl[8'h25], "level");
      chk(32'(cfg_hibernate), 32'(mdl[8'h25] == 4), "hibernate");
      chk(32'(tx_enable), 32'(mdl[8'h26] == 0), "tx");
      chk(32'(cfg_preset), mdl[8'h28], "preset");
      chk(cfg_decimation, mdl[8'h29], "decim");
      chk(cfg_averaging, mdl[8'h30], "avg");
      chk(32'(cfg_noise_scaling), 32'(mdl[8'h31] != 0), "norm");
      chk(32'(cfg_attenuation_max), 32'(mdl[8'h32] != 0), "atten");
      chk(32'(cfg_async_mode), 32'(mdl[8'h33] != 0), "async");
      chk(32'(cfg_long_span), 32'(mdl[8'h34] == 9), "long");
      chk(cfg_bin_total, mdl[8'h40], "bins");
   endtask
   task automatic wm(input logic [7:0] a, input logic [31:0] d);
      u_host.wr(a, d);
      if (legal(a, d))
         mdl[a] = d;
      #1 chk_cfg;
   endtask
   task automatic rm(input logic [7:0] a);
      logic [31:0] got;
      u_host.rd(a, got);
      chk(got, mdl[a], "read");
   endtask
   task automatic scan;
      for (int a = 0; a < 256; a++) begin
         rm(8'(a));
      end
   endtask
   task automatic create;
      logic [31:0] v [5];
      foreach (v[i]) v[i] = $urandom;
      @(posedge clk_sys);
      {created_begin_mm, created_span_mm, created_bins} <= {v[0], v[1], v[2]};
      {created_stitches, created_spacing_um} <= {v[3], v[4]};
      service_created <= 1'b1;
      @(posedge clk_sys);
      service_created <= 1'b0;
      foreach (v[i]) mdl[8'h81 + i] = v[i];
      {mdl[8'ha0], mdl[8'ha1], mdl[8'ha3]} = '0;
      for (int i = 0; i < 5; i++) begin
         rm(8'(8'h81 + i));
      end
   endtask
   task automatic count(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge clk_sys);
         #1 if (meas_start === 1'b1)
            c++;
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #100us;
      error_cnt++;
      report_and_stop;
   end
   initial begin
      logic [7:0] a;
      logic [31:0] d;
      int c, e;
      void'($urandom(88135));
      mreset;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      scan;
      chk_cfg;
      $display("test reset values done");
      foreach (codes[i])
         for (int v = 0; v < 11; v++) wm(codes[i], v);
      wm(8'h24, 1000);
      wm(8'h24, 1001);
      $display("test codes done");
      repeat (300) begin
         a = ($urandom % 2) ? CFG_OFFSET[$urandom % CFG_COUNT] : 8'($urandom);
         d = ($urandom % 2) ? $urandom % 12 : $urandom;
         wm(a, d);
         rm(a);
      end
      $display("test random traffic done");
      create;
      for (int f = 0; f < 8; f++) begin
         @(posedge clk_sys);
         {frame_saturated, frame_lost, frame_poor} <= 3'(f);
         data_produced <= 1'b1;
         @(posedge clk_sys);
         data_produced <= 1'b0;
         {frame_saturated, frame_lost, frame_poor} <= ~3'(f);
         {mdl[8'ha0], mdl[8'ha1], mdl[8'ha3]} = {32'(f / 4), 32'(f / 2 % 2), 32'(f % 2)};
         rm(8'ha1);
         rm(8'ha0);
         rm(8'ha3);
      end
      create;
      rm(8'ha1);
      for (int k = 1; k >= 0; k--) begin
         @(posedge clk_sys);
         link_failed <= 1'(k);
         mdl[8'ha4] = 32'(k);
         rm(8'ha4);
      end
      $display("test metadata done");
      wm(8'h22, 2);
      wm(8'h23, 0);
      @(posedge clk_sys);
      meas_request <= 1'b1;
      @(posedge clk_sys);
      meas_request <= 1'b0;
      #1 chk(32'(meas_start), 32'h1, "start");
      @(posedge clk_sys);
      #1 chk(32'(meas_start), 32'h0, "start end");
      // 2^31 mHz wraps about every 93 cycles at 200 MHz
      wm(8'h23, 32'h8000_0000);
      e = int'((64'd1000 << 31) / 64'd200000000000);
      count(1000, c);
      chk(32'(c), 32'h0, "no request");
      @(posedge clk_sys);
      meas_request <= 1'b1;
      count(1000, c);
      chk(32'(c >= e && c <= e + 2), 32'h1, "limited");
      @(posedge clk_sys);
      meas_request <= 1'b0;
      wm(8'h22, 1);
      count(1000, c);
      chk(32'(c >= e && c <= e + 1), 32'h1, "precise");
      $display("test pacing done");
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      mreset;
      scan;
      $display("test second reset done");
      report_and_stop;
   end
endmodule // power_bin_regs_tb

// ===== hdl/cadence_if.sv
// link between the register bank and the measurement pacer
`timescale 1ns/10ps
interface cadence_if;
   logic [31:0] policy;
   logic [31:0] rate;
   logic request;
   logic start;
   modport bank (output policy, output rate, output request, input start);
   modport pacer (input policy, input rate, input request, output start);
endinterface

// ===== hdl/measure_pacer.sv
// paces measurement starts from the cadence policy and millihertz rate
`timescale 1ns/10ps
module measure_pacer
   import pbin_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // from the bank
   cadence_if.pacer cad
);

   logic [39:0] phase;
   logic [39:0] next_phase;
   logic tick;
   pace_state_type state;
   pace_state_type next_state;
   logic start;
   logic next_start;

   ////////////////////////////////////////////////////////////////////////////
   // accumulator adds the rate in mHz every cycle; one wrap is one period
   // rate is 32 bits so the sum never passes two wraps
   always_comb begin
      logic [40:0] sum;
      sum = {1'b0, phase} + {9'h000, cad.rate};
      tick = 1'b0;
      next_phase = sum[39:0];
      if (sum >= {1'b0, PHASE_WRAP}) begin
         next_phase = 40'(sum - {1'b0, PHASE_WRAP});
         tick = 1'b1;
      end
   end

   always_comb begin
      next_state = state;
      next_start = 1'b0;
      case (cad.policy)
         POLICY_PRECISE: begin
            next_start = tick;
            next_state = PACE_HOLD;
         end
         POLICY_LIMITED: begin
            if (cad.rate == 32'h0000_0000) begin
               next_start = cad.request;
            end else begin
               case (state)
                  PACE_HOLD: begin
                     if (tick) begin
                        next_state = PACE_OPEN;
                     end
                  end
                  PACE_OPEN: begin
                     if (cad.request) begin
                        next_start = 1'b1;
                        // a tick in the same cycle reopens the window at once
                        next_state = tick ? PACE_OPEN : PACE_HOLD;
                     end
                  end
                  default: next_state = PACE_HOLD;
               endcase
            end
         end
         default: begin
            next_state = PACE_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         phase <= 40'h00_0000_0000;
         state <= PACE_HOLD;
         start <= 1'b0;
      end else begin
         phase <= next_phase;
         state <= next_state;
         start <= next_start;
      end
   end

   assign cad.start = start;

endmodule // measure_pacer

// ===== hdl/pbin_pkg.sv
// constants, offsets and reset values of the power-bin register bank
package pbin_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // configuration registers, writable
   localparam logic [7:0] OFS_MEASURE_BEGIN_MM = 8'h20;
   localparam logic [7:0] OFS_MEASURE_SPAN_MM = 8'h21;
   localparam logic [7:0] OFS_CADENCE_POLICY = 8'h22;
   localparam logic [7:0] OFS_CADENCE_MILLIHERTZ = 8'h23;
   localparam logic [7:0] OFS_RECEIVER_AMPLIFICATION = 8'h24;
   localparam logic [7:0] OFS_RADAR_SLEEP_LEVEL = 8'h25;
   localparam logic [7:0] OFS_TRANSMITTER_MUTE = 8'h26;
   localparam logic [7:0] OFS_RX_TX_PRESET = 8'h28;
   localparam logic [7:0] OFS_DECIMATION_FACTOR = 8'h29;
   localparam logic [7:0] OFS_HW_AVERAGING_COUNT = 8'h30;
   localparam logic [7:0] OFS_NOISE_SCALING_ENABLE = 8'h31;
   localparam logic [7:0] OFS_LEAKAGE_ATTENUATION_MAX = 8'h32;
   localparam logic [7:0] OFS_ASYNC_MEASURE_ENABLE = 8'h33;
   localparam logic [7:0] OFS_UNAMBIGUOUS_SPAN_SEL = 8'h34;
   localparam logic [7:0] OFS_WANTED_BIN_TOTAL = 8'h40;

   // metadata and flags, read only
   localparam logic [7:0] OFS_SWEEP_BEGIN_MM = 8'h81;
   localparam logic [7:0] OFS_SWEEP_SPAN_MM = 8'h82;
   localparam logic [7:0] OFS_BIN_TOTAL = 8'h83;
   localparam logic [7:0] OFS_SWEEP_STITCHES = 8'h84;
   localparam logic [7:0] OFS_POINT_SPACING_UM = 8'h85;
   localparam logic [7:0] OFS_SATURATION_FLAG = 8'ha0;
   localparam logic [7:0] OFS_LOST_DATA_FLAG = 8'ha1;
   localparam logic [7:0] OFS_QUALITY_WARNING_FLAG = 8'ha3;
   localparam logic [7:0] OFS_RADAR_LINK_FAULT_FLAG = 8'ha4;

   // index of each configuration register in the storage array
   localparam int CFG_COUNT = 15;
   localparam logic [3:0] IDX_BEGIN = 4'h0;
   localparam logic [3:0] IDX_SPAN = 4'h1;
   localparam logic [3:0] IDX_POLICY = 4'h2;
   localparam logic [3:0] IDX_RATE = 4'h3;
   localparam logic [3:0] IDX_GAIN = 4'h4;
   localparam logic [3:0] IDX_LEVEL = 4'h5;
   localparam logic [3:0] IDX_MUTE = 4'h6;
   localparam logic [3:0] IDX_PRESET = 4'h7;
   localparam logic [3:0] IDX_DECIM = 4'h8;
   localparam logic [3:0] IDX_AVG = 4'h9;
   localparam logic [3:0] IDX_NORM = 4'ha;
   localparam logic [3:0] IDX_ATTEN = 4'hb;
   localparam logic [3:0] IDX_ASYNC = 4'hc;
   localparam logic [3:0] IDX_UNAMB = 4'hd;
   localparam logic [3:0] IDX_BINS = 4'he;

   localparam logic [7:0] CFG_OFFSET [CFG_COUNT] = '{
      OFS_MEASURE_BEGIN_MM, OFS_MEASURE_SPAN_MM, OFS_CADENCE_POLICY,
      OFS_CADENCE_MILLIHERTZ, OFS_RECEIVER_AMPLIFICATION, OFS_RADAR_SLEEP_LEVEL,
      OFS_TRANSMITTER_MUTE, OFS_RX_TX_PRESET, OFS_DECIMATION_FACTOR,
      OFS_HW_AVERAGING_COUNT, OFS_NOISE_SCALING_ENABLE, OFS_LEAKAGE_ATTENUATION_MAX,
      OFS_ASYNC_MEASURE_ENABLE, OFS_UNAMBIGUOUS_SPAN_SEL, OFS_WANTED_BIN_TOTAL};

   // field encodings
   localparam logic [31:0] POLICY_PRECISE = 32'h0000_0001;
   localparam logic [31:0] POLICY_LIMITED = 32'h0000_0002;
   localparam logic [31:0] GAIN_MAX = 32'h0000_03e8;
   localparam logic [31:0] LEVEL_OFF = 32'h0000_0000;
   localparam logic [31:0] LEVEL_SLEEP = 32'h0000_0001;
   localparam logic [31:0] LEVEL_READY = 32'h0000_0002;
   localparam logic [31:0] LEVEL_ACTIVE = 32'h0000_0003;
   localparam logic [31:0] LEVEL_HIBERNATE = 32'h0000_0004;
   localparam logic [31:0] PRESET_FIRST = 32'h0000_0001;
   localparam logic [31:0] PRESET_LAST = 32'h0000_0005;
   localparam logic [31:0] SPAN_SEL_SHORT = 32'h0000_0006;
   localparam logic [31:0] SPAN_SEL_LONG = 32'h0000_0009;

   // values after reset
   localparam logic [31:0] CFG_RESET [CFG_COUNT] = '{
      32'h0000_00c8, 32'h0000_0190, POLICY_PRECISE, 32'h0000_0000, 32'h0000_01f4,
      LEVEL_OFF, 32'h0000_0000, PRESET_FIRST, 32'h0000_0001, 32'h0000_000a,
      32'h0000_0001, 32'h0000_0000, 32'h0000_0001, SPAN_SEL_SHORT, 32'h0000_0010};

   // timing: millihertz phase accumulator wraps once per second of clock
   localparam int CLK_PERIOD_NS = 5;
   localparam longint CLK_HZ = 64'd1000000000 / CLK_PERIOD_NS;
   localparam longint MILLI_PER_UNIT = 1000;
   localparam logic [39:0] PHASE_WRAP = 40'(CLK_HZ * MILLI_PER_UNIT);

   typedef enum logic {PACE_HOLD, PACE_OPEN} pace_state_type;

endpackage

// ===== hdl/power_bin_regs.sv
// power-bin register bank with configuration outputs and metadata capture
`timescale 1ns/10ps
//
// Notes on behaviour
// - writable registers configure, read-only hold metadata
// - policy 1 paces exactly, 2 limits rate
// - limited policy with rate zero: no limit
// - rate counts in millihertz steps
// - gain spans 0 lowest to 1000 highest
// - power level codes off, sleep, ready, active, hibernate
// - mute stops transmission for noise measurement
// - preset codes 1 to 5, resolution to gain
// - span select 6 short or 9 long
// - noise scaling enabled after reset
// - async mode follows its written value
// - measurement uses host's requested bin count
// - point spacing reported in micrometres
// - stitch count of current sweep reported
// - saturation flag marks saturated sensor data
// - lost-data flag true when data dropped
// - quality warning flag true on poor data
// - link fault flag true on sensor failure
// - begin and span registers hold millimetres
module power_bin_regs
   import pbin_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // measurement engine pacing
   input wire logic meas_request,
   output logic meas_start,
   // metadata from service creation
   input wire logic service_created,
   input wire logic [31:0] created_begin_mm,
   input wire logic [31:0] created_span_mm,
   input wire logic [31:0] created_bins,
   input wire logic [31:0] created_stitches,
   input wire logic [31:0] created_spacing_um,
   // per-frame status from the engine
   input wire logic data_produced,
   input wire logic frame_saturated,
   input wire logic frame_lost,
   input wire logic frame_poor,
   input wire logic link_failed,
   // configuration towards the sensor
   output logic [31:0] cfg_begin_mm,
   output logic [31:0] cfg_span_mm,
   output logic [9:0] cfg_gain,
   output logic [2:0] cfg_power_level,
   output logic cfg_hibernate,
   output logic tx_enable,
   output logic [2:0] cfg_preset,
   output logic [31:0] cfg_decimation,
   output logic [31:0] cfg_averaging,
   output logic cfg_noise_scaling,
   output logic cfg_attenuation_max,
   output logic cfg_async_mode,
   output logic cfg_long_span,
   output logic [31:0] cfg_bin_total
);

   ////////////////////////////////////////////////////////////////////////////
   // address decode shared by write and read paths
   function automatic logic [4:0] cfg_lookup(input logic [7:0] addr);
      logic [4:0] hit;
      hit = 5'h00;
      for (int i = 0; i < CFG_COUNT; i++) begin
         if (addr == CFG_OFFSET[i]) begin
            hit = {1'b1, 4'(i)};
         end
      end
      return hit;
   endfunction

   // a code outside the documented set leaves the register unchanged
   function automatic logic code_allowed(input logic [3:0] idx, input logic [31:0] val);
      logic ok;
      ok = 1'b1;
      if (idx == IDX_POLICY) begin
         ok = (val == POLICY_PRECISE) || (val == POLICY_LIMITED);
      end else if (idx == IDX_GAIN) begin
         ok = (val <= GAIN_MAX);
      end else if (idx == IDX_LEVEL) begin
         ok = (val <= LEVEL_HIBERNATE);
      end else if (idx == IDX_PRESET) begin
         ok = (val >= PRESET_FIRST) && (val <= PRESET_LAST);
      end else if (idx == IDX_UNAMB) begin
         ok = (val == SPAN_SEL_SHORT) || (val == SPAN_SEL_LONG);
      end
      return ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // configuration storage

   logic [31:0] cfg [CFG_COUNT];
   logic [31:0] next_cfg [CFG_COUNT];
   logic [4:0] wr_hit;

   assign wr_hit = cfg_lookup(reg_addr);

   always_comb begin
      for (int i = 0; i < CFG_COUNT; i++) begin
         next_cfg[i] = cfg[i];
      end
      if (reg_write && wr_hit[4] && code_allowed(wr_hit[3:0], reg_wdata)) begin
         next_cfg[wr_hit[3:0]] = reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < CFG_COUNT; i++) begin
            cfg[i] <= CFG_RESET[i];
         end
      end else begin
         for (int i = 0; i < CFG_COUNT; i++) begin
            cfg[i] <= next_cfg[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration outputs; codes are checked on write so slices are safe

   always_comb begin
      cfg_begin_mm = cfg[IDX_BEGIN];
      cfg_span_mm = cfg[IDX_SPAN];
      cfg_gain = cfg[IDX_GAIN][9:0];
      cfg_power_level = cfg[IDX_LEVEL][2:0];
      // hibernate entry itself needs the host's pin toggling
      cfg_hibernate = (cfg[IDX_LEVEL] == LEVEL_HIBERNATE);
      tx_enable = (cfg[IDX_MUTE] == 32'h0000_0000);
      cfg_preset = cfg[IDX_PRESET][2:0];
      cfg_decimation = cfg[IDX_DECIM];
      cfg_averaging = cfg[IDX_AVG];
      cfg_noise_scaling = (cfg[IDX_NORM] != 32'h0000_0000);
      cfg_attenuation_max = (cfg[IDX_ATTEN] != 32'h0000_0000);
      cfg_async_mode = (cfg[IDX_ASYNC] != 32'h0000_0000);
      cfg_long_span = (cfg[IDX_UNAMB] == SPAN_SEL_LONG);
      cfg_bin_total = cfg[IDX_BINS];
   end

   ////////////////////////////////////////////////////////////////////////////
   // pacing

   cadence_if cad ();

   assign cad.policy = cfg[IDX_POLICY];
   assign cad.rate = cfg[IDX_RATE];
   assign cad.request = meas_request;
   assign meas_start = cad.start;

   measure_pacer pacer (
      .clk_sys (clk_sys),
      .rstn (rstn),
      .cad (cad)
   );

   ////////////////////////////////////////////////////////////////////////////
   // metadata captured at creation, frame flags at each produced frame, link fault flag every cycle

   logic [31:0] sweep_begin_mm;
   logic [31:0] sweep_span_mm;
   logic [31:0] bin_total;
   logic [31:0] sweep_stitches;
   logic [31:0] point_spacing_um;
   logic saturation_flag;
   logic lost_data_flag;
   logic quality_warning_flag;
   logic radar_link_fault_flag;
   logic [31:0] next_sweep_begin_mm;
   logic [31:0] next_sweep_span_mm;
   logic [31:0] next_bin_total;
   logic [31:0] next_sweep_stitches;
   logic [31:0] next_point_spacing_um;
   logic next_saturation_flag;
   logic next_lost_data_flag;
   logic next_quality_warning_flag;
   logic next_radar_link_fault_flag;

   always_comb begin
      next_sweep_begin_mm = sweep_begin_mm;
      next_sweep_span_mm = sweep_span_mm;
      next_bin_total = bin_total;
      next_sweep_stitches = sweep_stitches;
      next_point_spacing_um = point_spacing_um;
      next_saturation_flag = saturation_flag;
      next_lost_data_flag = lost_data_flag;
      next_quality_warning_flag = quality_warning_flag;
      if (service_created) begin
         next_sweep_begin_mm = created_begin_mm;
         next_sweep_span_mm = created_span_mm;
         next_bin_total = created_bins;
         next_sweep_stitches = created_stitches;
         next_point_spacing_um = created_spacing_um;
         // a fresh service starts with clean frame flags
         next_saturation_flag = 1'b0;
         next_lost_data_flag = 1'b0;
         next_quality_warning_flag = 1'b0;
      end
      // a frame in the same cycle as creation wins over the clearing
      if (data_produced) begin
         next_saturation_flag = frame_saturated;
         next_lost_data_flag = frame_lost;
         next_quality_warning_flag = frame_poor;
      end
      // follows the engine's level so a recovered link reads clean
      next_radar_link_fault_flag = link_failed;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sweep_begin_mm <= 32'h0000_0000;
         sweep_span_mm <= 32'h0000_0000;
         bin_total <= 32'h0000_0000;
         sweep_stitches <= 32'h0000_0000;
         point_spacing_um <= 32'h0000_0000;
         saturation_flag <= 1'b0;
         lost_data_flag <= 1'b0;
         quality_warning_flag <= 1'b0;
         radar_link_fault_flag <= 1'b0;
      end else begin
         sweep_begin_mm <= next_sweep_begin_mm;
         sweep_span_mm <= next_sweep_span_mm;
         bin_total <= next_bin_total;
         sweep_stitches <= next_sweep_stitches;
         point_spacing_um <= next_point_spacing_um;
         saturation_flag <= next_saturation_flag;
         lost_data_flag <= next_lost_data_flag;
         quality_warning_flag <= next_quality_warning_flag;
         radar_link_fault_flag <= next_radar_link_fault_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path: data valid the cycle after the strobe only, zero otherwise

   logic [31:0] next_rdata;
   logic [4:0] rd_hit;

   assign rd_hit = cfg_lookup(reg_addr);

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_read) begin
         if (rd_hit[4]) begin
            next_rdata = cfg[rd_hit[3:0]];
         end else if (reg_addr == OFS_SWEEP_BEGIN_MM) begin
            next_rdata = sweep_begin_mm;
         end else if (reg_addr == OFS_SWEEP_SPAN_MM) begin
            next_rdata = sweep_span_mm;
         end else if (reg_addr == OFS_BIN_TOTAL) begin
            next_rdata = bin_total;
         end else if (reg_addr == OFS_SWEEP_STITCHES) begin
            next_rdata = sweep_stitches;
         end else if (reg_addr == OFS_POINT_SPACING_UM) begin
            next_rdata = point_spacing_um;
         end else if (reg_addr == OFS_SATURATION_FLAG) begin
            next_rdata = {31'h0000_0000, saturation_flag};
         end else if (reg_addr == OFS_LOST_DATA_FLAG) begin
            next_rdata = {31'h0000_0000, lost_data_flag};
         end else if (reg_addr == OFS_QUALITY_WARNING_FLAG) begin
            next_rdata = {31'h0000_0000, quality_warning_flag};
         end else if (reg_addr == OFS_RADAR_LINK_FAULT_FLAG) begin
            next_rdata = {31'h0000_0000, radar_link_fault_flag};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

endmodule // power_bin_regs
